//--- inc/rac_map.svh
`ifndef RAC_MAP_SVH
`define RAC_MAP_SVH
// ****************************************************************
// fixed region boundaries
// ****************************************************************
`define RAC_SYS_END      32'h0000_00c8
`define RAC_R0_START     32'h0000_00c8
`define RAC_R3_END       32'h0002_0000
`define RAC_R4_START     32'h1000_0000
`define RAC_R4_END       32'h1000_2000
// ****************************************************************
// reset values of the movable boundaries
// ****************************************************************
`define RAC_R0_END_RST   32'h0000_1000
`define RAC_R1_END_RST   32'h0000_2000
`define RAC_R2_END_RST   32'h0000_3000
// ****************************************************************
// protection configuration register window
// ****************************************************************
`define RAC_CFG_BASE     32'h4004_0000
`define RAC_CFG_TOP      32'h4004_0100
`define RAC_MON_ADDR     32'h4004_00a0
// ****************************************************************
// peripheral space (always permitted)
// ****************************************************************
`define RAC_PERI_BASE    32'h4000_0000
`define RAC_PERI_TOP     32'h6000_0000
`define RAC_CPU_BASE     32'he000_0000
// ****************************************************************
// cause bit positions
// ****************************************************************
`define RAC_CB_DMA       0
`define RAC_CB_CFG       1
`define RAC_CB_ADJ       2
`define RAC_CB_DOWN      3
`define RAC_CB_SYS       4
`define RAC_NCAUSE       5
`endif

//--- inc/rac_pkg.sv
package rac_pkg;
   // region classification of an address
   typedef enum logic [3:0] {
      RAC_RG_SYS,
      RAC_RG_R0,
      RAC_RG_R1,
      RAC_RG_R2,
      RAC_RG_R3,
      RAC_RG_R4,
      RAC_RG_CFG,
      RAC_RG_MON,
      RAC_RG_PERI,
      RAC_RG_INVALID
   } rac_region_e;
   typedef logic [4:0] rac_cause_t;
endpackage : rac_pkg

//--- rtl/rac_checker.sv
`timescale 1ns/1ns
`include "rac_map.svh"
// Summary of operation
// - a rule-breaking access is aborted and the protection interrupt is raised
// - all causes share one interrupt line; each cause recorded in the monitor
// - dma copy between mutually inaccessible regions flags dma invalid abort
// - config register write from system, or code gives config abort
// - monitor register is readable and writable from every region without abort
// - r0 and code may write config; ..may only read it
// - write into region exactly one level lower gives adjacent write abort
// - read into region one level lower gives no adjacent write abort
// - access two or more levels lower gives downward abort, not adjacent abort
// - system code accessing r0..gives downward abort; allowed
// - write into system region from r0..gives system write abort
// - option 0: may read reading r0..gives downward abort
// - option 1: reading r0..gives downward abort
// - dma never reaches protection configuration registers other than the monitor while protection is enabled
// - dma is checked with permissions of the region that started it
// - any violation asserts protection interrupt and monitor shows the case
// - with protection disabled every region is freely accessible
// - address in region when start <= address < end
// - system region is the fixed range from zero up to c8
module rac_checker
   import rac_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // configuration
   input  wire logic        protection_enable_bit,
   input  wire logic        region_option,
   input  wire logic [31:0] r0_end,
   input  wire logic [31:0] r1_end,
   input  wire logic [31:0] r2_end,
   // master request
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_pc,
   input  wire logic        req_dma,
   input  wire logic        dma_m2m,
   input  wire logic [31:0] dma_other_addr,
   input  wire logic [31:0] req_wdata,
   // gated request toward memory
   output logic             mem_valid,
   output logic             mem_write,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic [31:0] mem_rdata,
   output logic [31:0]      req_rdata,
   output logic             req_abort,
   // monitor register access
   input  wire logic        mon_wr,
   input  wire logic [4:0]  mon_wdata,
   output logic [4:0]       abort_cause_monitor,
   // interrupt
   output logic             protection_irq
);
   // ****************************************************************
   // region decode of target, code and dma partner
   // ****************************************************************
   rac_region_e tgt_rg;
   rac_region_e code_rg;
   rac_region_e oth_rg;
   rac_cause_t  cause;
   rac_cause_t  oth_cause;
   rac_cause_t  mon_q;
   logic        blk;
   logic        dma_bad;

   rac_classify u_tgt (.addr(req_addr), .r0_end(r0_end), .r1_end(r1_end),
                       .r2_end(r2_end), .region(tgt_rg));
   rac_classify u_code (.addr(req_pc), .r0_end(r0_end), .r1_end(r1_end),
                        .r2_end(r2_end), .region(code_rg));
   rac_classify u_oth (.addr(dma_other_addr), .r0_end(r0_end), .r1_end(r1_end),
                       .r2_end(r2_end), .region(oth_rg));

   // level of a memory region: system is below only access
   function automatic logic [2:0] rac_lvl(input rac_region_e r);
      case (r)
         RAC_RG_R0: rac_lvl = 3'h0;
         RAC_RG_R1: rac_lvl = 3'h1;
         RAC_RG_R2: rac_lvl = 3'h2;
         RAC_RG_R3: rac_lvl = 3'h3;
         default:   rac_lvl = 3'h4;
      endcase
   endfunction : rac_lvl

   function automatic logic rac_is_mem(input rac_region_e r);
      rac_is_mem = (r == RAC_RG_R0) || (r == RAC_RG_R1) || (r == RAC_RG_R2) ||
                   (r == RAC_RG_R3) || (r == RAC_RG_R4);
   endfunction : rac_is_mem

   // one-hot cause for code region c touching target t; zero if allowed
   function automatic rac_cause_t rac_judge(input rac_region_e c, input rac_region_e t,
                                            input logic wr, input logic opt);
      rac_cause_t  k;
      logic [2:0]  cl;
      logic [2:0]  tl;
      k  = '0;
      cl = rac_lvl(c);
      tl = rac_lvl(t);
      if (t == RAC_RG_CFG)
      begin
         if (wr && !(c == RAC_RG_R0 || c == RAC_RG_R1))
            k[`RAC_CB_CFG] = 1'b1;
      end
      else if (t == RAC_RG_SYS)
      begin
         if (wr && c != RAC_RG_SYS)
            k[`RAC_CB_SYS] = 1'b1;
      end
      else if (c == RAC_RG_SYS)
      begin
         if (rac_is_mem(t) && t != RAC_RG_R4)
            k[`RAC_CB_DOWN] = 1'b1;
      end
      else if (rac_is_mem(c) && rac_is_mem(t) && tl < cl)
      begin
         if (cl - tl == 3'h1)
         begin
            // r4 code reading one level lower under option 1 is a downward abort
            if (c == RAC_RG_R4 && !wr && opt)
               k[`RAC_CB_DOWN] = 1'b1;
            else if (wr)
               k[`RAC_CB_ADJ] = 1'b1;
         end
         else
            k[`RAC_CB_DOWN] = 1'b1;
      end
      rac_judge = k;
   endfunction : rac_judge

   // ****************************************************************
   // classification; monitor address never aborts
   // ****************************************************************
   always_comb
   begin
      oth_cause = rac_judge(code_rg, oth_rg, 1'b0, region_option);
      dma_bad   = req_dma && dma_m2m && (oth_cause != '0 ||
                  (rac_is_mem(oth_rg) && rac_is_mem(tgt_rg) &&
                   rac_judge(oth_rg, tgt_rg, req_write, region_option) != '0));
      cause = '0;
      if (!protection_enable_bit || !req_valid || tgt_rg == RAC_RG_MON)
         cause = '0;
      else if (req_dma && tgt_rg == RAC_RG_CFG)
         cause[`RAC_CB_DMA] = 1'b1;
      else if (dma_bad)
         cause[`RAC_CB_DMA] = 1'b1;
      else
         cause = rac_judge(code_rg, tgt_rg, req_write, region_option);
   end

   assign blk       = cause != '0;
   assign req_abort = blk;

   // ****************************************************************
   // access gating
   // ****************************************************************
   // blocked request never reaches memory, so no write lands
   assign mem_valid = req_valid && !blk;
   assign mem_write = req_write;
   assign mem_addr  = req_addr;
   assign mem_wdata = req_wdata;
   assign req_rdata = blk ? 32'h0000_0000 : mem_rdata;

   // ****************************************************************
   // monitor register: sticky, write-one-to-clear, set wins
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         mon_q <= '0;
      else if (mon_wr)
         mon_q <= (mon_q & ~mon_wdata) | cause;
      else
         mon_q <= mon_q | cause;
   end

   assign abort_cause_monitor = mon_q;

   // single line; level while any cause is held
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         protection_irq <= 1'b0;
      else
         protection_irq <= |(mon_q | cause);
   end
endmodule : rac_checker

//--- rtl/rac_classify.sv
`timescale 1ns/1ns
`include "rac_map.svh"
module rac_classify
   import rac_pkg::*;
(
   // address and movable boundaries
   input  wire logic [31:0] addr,
   input  wire logic [31:0] r0_end,
   input  wire logic [31:0] r1_end,
   input  wire logic [31:0] r2_end,
   // region of the address
   output rac_region_e      region
);
   // ****************************************************************
   // region decode, start <= addr < end
   // ****************************************************************
   always_comb
   begin
      if (addr < `RAC_SYS_END)
         region = RAC_RG_SYS;
      else if (addr < r0_end)
         region = RAC_RG_R0;
      else if (addr < r1_end)
         region = RAC_RG_R1;
      else if (addr < r2_end)
         region = RAC_RG_R2;
      else if (addr < `RAC_R3_END)
         region = RAC_RG_R3;
      else if (addr >= `RAC_R4_START && addr < `RAC_R4_END)
         region = RAC_RG_R4;
      else if (addr == `RAC_MON_ADDR)
         region = RAC_RG_MON;
      else if (addr >= `RAC_CFG_BASE && addr < `RAC_CFG_TOP)
         region = RAC_RG_CFG;
      else if ((addr >= `RAC_PERI_BASE && addr < `RAC_PERI_TOP) || addr >= `RAC_CPU_BASE)
         region = RAC_RG_PERI;
      else
         region = RAC_RG_INVALID;
   end
endmodule : rac_classify

//--- tb/rac_checker_properties.sv
`timescale 1ns/1ns
// ***
// port checks of the abort logic
// ***
module rac_checker_properties
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        srst,
   // request and memory side
   input wire logic        protection_enable_bit,
   input wire logic        req_valid,
   input wire logic        req_abort,
   input wire logic [31:0] req_rdata,
   input wire logic        mem_valid,
   // monitor and interrupt
   input wire logic        mon_wr,
   input wire logic [4:0]  mon_wdata,
   input wire logic [4:0]  abort_cause_monitor,
   input wire logic        protection_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic       blk;
   logic [4:0] prev_q, wipe_q;
   assign blk = req_valid && req_abort;
   // last cycle's causes, so a new bit can be told from an old one
   always_ff @(posedge clk_sys)
      prev_q <= srst ? 5'h0 : abort_cause_monitor;
   // set wins over clear, so a clear beside an abort is left out
   always_ff @(posedge clk_sys)
      wipe_q <= (srst || !mon_wr || blk) ? 5'h0 : mon_wdata;
   sequence s_blocked;
      !mem_valid && req_rdata == 32'h0;
   endsequence
   sequence s_flagged;
      abort_cause_monitor != 5'h0 && protection_irq;
   endsequence
   a_abort_blocks_flags: assert property (blk |-> s_blocked ##1 s_flagged)
      else $error("aborted access not blocked and flagged");
   a_pass_allowed: assert property (req_valid && !req_abort |-> mem_valid)
      else $error("allowed access not passed on");
   a_disabled_open: assert property (!protection_enable_bit |-> !req_abort)
      else $error("abort while protection disabled");
   a_one_cause: assert property ($onehot0(abort_cause_monitor & ~prev_q))
      else $error("more than one cause set at once");
   a_causes_stick: assert property (!blk && !mon_wr |=> $stable(abort_cause_monitor))
      else $error("monitor changed without cause");
   a_clear_works: assert property ((abort_cause_monitor & wipe_q) == 5'h0)
      else $error("monitor bit not cleared");
   a_irq_tracks: assert property (|abort_cause_monitor |-> protection_irq)
      else $error("interrupt low with cause pending");
   a_irq_drops: assert property (abort_cause_monitor == 5'h0 && !blk |=> !protection_irq)
      else $error("interrupt high without cause");
endmodule : rac_checker_properties
bind rac_checker rac_checker_properties rac_checker_properties_i (.clk_sys, .srst,
   .protection_enable_bit, .req_valid, .req_abort, .req_rdata, .mem_valid, .mon_wr,
   .mon_wdata, .abort_cause_monitor, .protection_irq);

//--- tb/rac_checker_test.sv
`timescale 1ns/1ns
`include "rac_map.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module rac_checker_test;
   localparam logic [31:0] A_SYS = 32'h0000_0040, A_0 = 32'h0000_0500, A_1 = 32'h0000_1500;
   localparam logic [31:0] A_2 = 32'h0000_2500, A_3 = 32'h0000_4000, A_4 = 32'h1000_0100;
   localparam logic [31:0] A_CFG = `RAC_CFG_BASE + 32'h14, A_MON = `RAC_MON_ADDR;
   logic        clk_sys, srst, protection_enable_bit, region_option, req_valid, req_write;
   logic        req_dma, dma_m2m, mon_wr, mem_valid, mem_write, req_abort, protection_irq;
   logic [31:0] r0_end, r1_end, r2_end, req_addr, req_pc, dma_other_addr, req_wdata;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, req_rdata, seen;
   logic [4:0]  mon_wdata, abort_cause_monitor;
   int          mismatches = 0, checks_done = 0;
   rac_checker rac_checker_i (.clk_sys, .srst, .protection_enable_bit, .region_option, .r0_end,
      .r1_end, .r2_end, .req_valid, .req_write, .req_addr, .req_pc, .req_dma, .dma_m2m,
      .dma_other_addr, .req_wdata, .mem_valid, .mem_write, .mem_addr, .mem_wdata, .mem_rdata,
      .req_rdata, .req_abort, .mon_wr, .mon_wdata, .abort_cause_monitor, .protection_irq);
   rac_mem_model rac_mem_model_i (.clk_sys, .mem_valid, .mem_write, .mem_addr, .mem_wdata,
      .mem_rdata);
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   // one access; the monitor is expected to read m an edge later
   task automatic go(input logic [31:0] pc, input logic [31:0] a, input logic w,
                     input logic [4:0] m);
      @(posedge clk_sys);
      req_pc    <= pc;
      req_addr  <= a;
      req_write <= w;
      req_valid <= 1'b1;
      @(negedge clk_sys);
      seen = req_rdata;
      `CHK("req_abort", m != 5'h0, req_abort)
      `CHK("mem_valid", m == 5'h0, mem_valid)
      if (m != 5'h0)
         `CHK("req_rdata", 32'h0000_0000, seen)
      @(posedge clk_sys);
      req_valid <= 1'b0;
      @(negedge clk_sys);
      `CHK("abort_cause_monitor", m, abort_cause_monitor)
      `CHK("protection_irq", m != 5'h0, protection_irq)
   endtask : go
   task automatic clr(input logic [4:0] m);
      @(posedge clk_sys);
      mon_wr    <= 1'b1;
      mon_wdata <= m;
      @(posedge clk_sys);
      mon_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : clr
   task automatic acc(input logic [31:0] pc, input logic [31:0] a, input logic w,
                      input logic [4:0] m);
      go(pc, a, w, m);
      clr(5'h1f);
   endtask : acc
   task automatic t_writes;
      acc(A_3, A_2, 1'b1, 5'h04);
      acc(A_1, A_0, 1'b1, 5'h04);
      acc(A_3, 32'h0000_2ffc, 1'b1, 5'h04);
      acc(A_3, `RAC_R2_END_RST, 1'b1, 5'h00);
      acc(A_3, A_1, 1'b1, 5'h08);
      acc(A_4, A_2, 1'b1, 5'h08);
      acc(A_SYS, A_3, 1'b1, 5'h08);
      acc(A_SYS, A_4, 1'b1, 5'h00);
      acc(A_0, 32'h0000_00c4, 1'b1, 5'h10);
      acc(A_4, A_SYS, 1'b1, 5'h10);
      acc(A_SYS, A_CFG, 1'b1, 5'h02);
      acc(A_2, A_CFG, 1'b1, 5'h02);
      acc(A_1, A_CFG, 1'b1, 5'h00);
      acc(A_4, A_MON, 1'b1, 5'h00);
   endtask : t_writes
   task automatic t_reads;
      acc(A_3, A_2, 1'b0, 5'h00);
      acc(A_2, A_0, 1'b0, 5'h08);
      acc(A_SYS, A_0, 1'b0, 5'h08);
      acc(A_3, A_CFG, 1'b0, 5'h00);
      acc(A_4, A_3, 1'b0, 5'h00);
      acc(A_4, A_2, 1'b0, 5'h08);
      @(posedge clk_sys);
      region_option <= 1'b1;
      acc(A_4, A_3, 1'b0, 5'h08);
      @(posedge clk_sys);
      region_option <= 1'b0;
   endtask : t_reads
   task automatic t_dma;
      @(posedge clk_sys);
      req_dma <= 1'b1;
      acc(A_3, A_0, 1'b0, 5'h08);
      acc(A_0, A_CFG, 1'b0, 5'h01);
      @(posedge clk_sys);
      dma_m2m        <= 1'b1;
      dma_other_addr <= A_3;
      acc(A_0, A_1, 1'b1, 5'h01);
      acc(A_0, A_4, 1'b1, 5'h00);
      @(posedge clk_sys);
      req_dma               <= 1'b0;
      dma_m2m               <= 1'b0;
      protection_enable_bit <= 1'b0;
      acc(A_3, A_0, 1'b1, 5'h00);
      @(posedge clk_sys);
      protection_enable_bit <= 1'b1;
   endtask : t_dma
   task automatic t_stick;
      @(posedge clk_sys);
      req_wdata <= 32'h0000_a5a5;
      go(A_0, A_1, 1'b1, 5'h00);
      @(posedge clk_sys);
      req_wdata <= 32'h0000_5a5a;
      go(A_2, A_1, 1'b1, 5'h04);
      go(A_0, A_SYS, 1'b1, 5'h14);
      clr(5'h04);
      // look away from the edge that updates the monitor
      @(negedge clk_sys);
      `CHK("abort_cause_monitor", 5'h10, abort_cause_monitor)
      `CHK("protection_irq", 1'b1, protection_irq)
      clr(5'h10);
      go(A_1, A_1, 1'b0, 5'h00);
      `CHK("req_rdata", 32'h0000_a5a5, seen)
   endtask : t_stick
   initial
   begin
      srst                  = 1'b1;
      protection_enable_bit = 1'b1;
      {req_valid, req_write, req_dma, dma_m2m, mon_wr, region_option} = 6'h0;
      {req_addr, req_pc, dma_other_addr, req_wdata} = 128'h0;
      mon_wdata = 5'h0;
      // ordered, non-overlapping boundaries as software must keep them
      r0_end = `RAC_R0_END_RST;
      r1_end = `RAC_R1_END_RST;
      r2_end = `RAC_R2_END_RST;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      `CHK("abort_cause_monitor", 5'h00, abort_cause_monitor)
      `CHK("protection_irq", 1'b0, protection_irq)
      t_writes();
      t_reads();
      t_dma();
      t_stick();
      wrap_up();
   end
endmodule : rac_checker_test

//--- tb/rac_mem_model.sv
`timescale 1ns/1ns
// ***
// far-side memory; an idle read bus shows a moving pattern, never stale data
// ***
module rac_mem_model
(
   // bus from the checker
   input  wire logic        clk_sys,
   input  wire logic        mem_valid,
   input  wire logic        mem_write,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic [31:0]      mem_rdata
);
   logic [31:0] mem_q [16];
   logic [31:0] pat_q;
   // plain always so the initial block may also drive pat_q and the pattern starts from a known value
   initial
      pat_q = 32'h0000_0000;
   always @(posedge clk_sys)
   begin
      pat_q <= pat_q + 32'h3c6e_f35f;
      if (mem_valid && mem_write)
         mem_q[mem_addr[5:2]] <= mem_wdata;
   end
   assign mem_rdata = (mem_valid && !mem_write) ? mem_q[mem_addr[5:2]] : pat_q;
endmodule : rac_mem_model
